// >>> core/eqr_regs.sv
// How it works
// - Ten-bit feedback channel register; logical channel maps to a physical one.
// - Feedback status bit 9 flags an invalid channel or offset.
// - Feedback status bit 8 shows busy while an operation runs.
// - Writing status bit 1 starts a read, bit 0 starts a write.
// - Six-bit offset register selects the indirect feedback register.
// - Sixteen-bit data register holds write data or read result.
// - Offset 0 bit 1 clear powers equalizer down; set powers it up.
// - Offset 0 bit 0 set enables the adaptation engine.
// - Offset 1 holds the four-bit first tap coefficient, 0 to 15.
// - Offsets 2 to 4 hold sign in bit 3, coefficient 0 to 7.
// - Offset 5 holds sign and coefficient limited to 0 to 3.
// - Any write to offset 0xB powers up and enters triggered mode.
// - Reading offset 0xB bit 0 returns 1 while in triggered mode.
// - Clearing power bit at offset 0 leaves triggered mode.
// - When busy drops after a write, staged data is applied.
// - Writing 2 to offset 0 powers on with adaptation off.
// - Linear set has channel and status registers with same bit layout.
// - Linear set has four-bit offset and sixteen-bit data registers.
// - Linear error flag asserts on an invalid channel.
// - Linear mode 0 is manual, 1 is one adaptation; 2 and 3 reserved.
// - Done flag bit 8 asserts after adaptation, up to 50,000 cycles.
// - Read-only four-bit result reports the adapted setting.
`timescale 1ns/1ps
module eqr_regs #(
	parameter int NUM_CH = eqr_pkg::NUM_CH_DEF,
	parameter int OP_CYCLES = eqr_pkg::OP_CYCLES_DEF,
	parameter int ADAPT_CYCLES = eqr_pkg::ADAPT_CYCLES_DEF
) (
	input wire logic ref_clk, // Reconfiguration clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [6:0] mgmt_address, // Word address.
	input wire logic mgmt_read, // Read strobe.
	input wire logic mgmt_write, // Write strobe.
	input wire logic [31:0] mgmt_writedata, // Write data.
	output logic [31:0] mgmt_readdata, // Read data, one cycle after strobe.
	input wire logic [NUM_CH-1:0][3:0] aeq_result_in, // Adapted setting.
	output logic [NUM_CH-1:0] dfe_power, // Feedback equalizer powered.
	output logic [NUM_CH-1:0] dfe_adapt_en, // Continuous adaptation on.
	output logic [NUM_CH-1:0] dfe_trig, // Triggered adaptation mode.
	output logic [NUM_CH-1:0][3:0] dfe_tap1, // First tap coefficient.
	output logic [NUM_CH-1:0][3:0][3:0] dfe_tap, // Taps 2..5 sign, coef.
	output logic [NUM_CH-1:0][1:0] aeq_mode, // Linear equalizer mode.
	output logic [NUM_CH-1:0] aeq_done // Linear adaptation finished.
);

	localparam int CHW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
	localparam int OCW = $clog2(OP_CYCLES + 1);
	localparam int ACW = $clog2(ADAPT_CYCLES + 1);

	typedef struct packed {
		logic [9:0] dfe_chan;
		logic [5:0] dfe_ofs;
		logic [15:0] dfe_data;
		logic dfe_err;
		logic [9:0] aeq_chan;
		logic [3:0] aeq_ofs;
		logic [15:0] aeq_data;
		logic aeq_err;
		eqr_pkg::eqr_op_e op;
		logic op_wr;
		logic [OCW-1:0] op_cnt;
		logic [NUM_CH-1:0] pwr;
		logic [NUM_CH-1:0] adapt;
		logic [NUM_CH-1:0] trig;
		logic [NUM_CH-1:0][3:0] tap1;
		logic [NUM_CH-1:0][3:0][3:0] tap;
		logic [NUM_CH-1:0][1:0] mode;
		logic [NUM_CH-1:0] done;
		logic [NUM_CH-1:0][3:0] result;
		logic ad_run;
		logic [CHW-1:0] ad_ch;
		logic [ACW-1:0] ad_cnt;
		logic [31:0] rdata;
	} eqr_state_s;

	eqr_state_s st_reg;
	eqr_state_s st_next;

	////////////////////////////////////////////////////////////////////////
	// Logical channels map one to one onto physical lanes; a remap table
	// would slot in here without touching the sequencer.
	// channel translation
	function automatic logic [CHW-1:0] phys_of(input logic [9:0] ch);
		phys_of = ch[CHW-1:0];
	endfunction

	// A logical channel is valid only if a physical lane stands behind it.
	function automatic logic chan_ok(input logic [9:0] ch);
		chan_ok = (int'(ch) < NUM_CH);
	endfunction

	function automatic logic dfe_ofs_ok(input logic [5:0] o);
		dfe_ofs_ok = (o <= eqr_pkg::DFE_TAP5_OFS) ||
			(o == eqr_pkg::DFE_TRIG_OFS);
	endfunction

	// Status word layout, shared by both register sets.
	// same bit layout
	function automatic logic [31:0] csr_word(input logic busy, input logic err);
		csr_word = '0;
		csr_word[eqr_pkg::CSR_BUSY_BIT] = busy;
		csr_word[eqr_pkg::CSR_ERR_BIT] = err;
	endfunction

	function automatic logic in_map(input logic [6:0] a);
		case (a)
			eqr_pkg::DFE_CHAN_ADDR, eqr_pkg::DFE_CSR_ADDR,
			eqr_pkg::DFE_OFS_ADDR, eqr_pkg::DFE_DATA_ADDR,
			eqr_pkg::AEQ_CHAN_ADDR, eqr_pkg::AEQ_CSR_ADDR,
			eqr_pkg::AEQ_OFS_ADDR, eqr_pkg::AEQ_DATA_ADDR: in_map = 1'b1;
			default: in_map = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Decoded commands and sequencer milestones.
	logic [CHW-1:0] dch;
	logic [CHW-1:0] ach;
	logic [1:0] ti;
	logic dfe_busy;
	logic aeq_busy;
	logic dfe_cmd;
	logic aeq_cmd;
	logic dfe_fin;
	logic aeq_fin;
	logic aeq_ok;

	assign dch = phys_of(st_reg.dfe_chan);
	assign ach = phys_of(st_reg.aeq_chan);
	assign ti = 2'(st_reg.dfe_ofs[1:0] - 2'h2);
	assign dfe_busy = (st_reg.op == eqr_pkg::OP_DFE);
	assign aeq_busy = (st_reg.op == eqr_pkg::OP_AEQ);

	// A command while either set is busy is dropped, so the host must poll.
	// one command at a time
	assign dfe_cmd = mgmt_write && (mgmt_address == eqr_pkg::DFE_CSR_ADDR) &&
		(mgmt_writedata[eqr_pkg::CSR_RD_BIT] ||
		mgmt_writedata[eqr_pkg::CSR_WR_BIT]) &&
		(st_reg.op == eqr_pkg::OP_IDLE);
	assign aeq_cmd = mgmt_write && (mgmt_address == eqr_pkg::AEQ_CSR_ADDR) &&
		(mgmt_writedata[eqr_pkg::CSR_RD_BIT] ||
		mgmt_writedata[eqr_pkg::CSR_WR_BIT]) &&
		(st_reg.op == eqr_pkg::OP_IDLE);
	assign dfe_fin = dfe_busy && (st_reg.op_cnt == OCW'(OP_CYCLES - 1));
	assign aeq_fin = aeq_busy && (st_reg.op_cnt == OCW'(OP_CYCLES - 1));

	// Reserved mode 2 and 3 are refused as errors rather than stored.
	// invalid channel
	assign aeq_ok = chan_ok(st_reg.aeq_chan) &&
		(st_reg.aeq_ofs <= eqr_pkg::AEQ_RESULT_OFS) &&
		!(mgmt_writedata[eqr_pkg::CSR_WR_BIT] &&
		(st_reg.aeq_ofs == eqr_pkg::AEQ_MODE_OFS) && st_reg.aeq_data[1]);

	////////////////////////////////////////////////////////////////////////
	// Next state: bus writes, commands, adaptation, commit, then bus reads.
	// Commit follows bus writes so the loaded read result wins a collision.
	always_comb
	begin
		st_next = st_reg;
		if (mgmt_write)
		begin
			case (mgmt_address)
				eqr_pkg::DFE_CHAN_ADDR: st_next.dfe_chan = mgmt_writedata[9:0];
				eqr_pkg::DFE_OFS_ADDR: st_next.dfe_ofs = mgmt_writedata[5:0];
				eqr_pkg::DFE_DATA_ADDR: st_next.dfe_data = mgmt_writedata[15:0];
				eqr_pkg::AEQ_CHAN_ADDR: st_next.aeq_chan = mgmt_writedata[9:0];
				eqr_pkg::AEQ_OFS_ADDR: st_next.aeq_ofs = mgmt_writedata[3:0];
				eqr_pkg::AEQ_DATA_ADDR: st_next.aeq_data = mgmt_writedata[15:0];
				default: ;
			endcase
		end

		if (dfe_cmd)
		begin
			if (chan_ok(st_reg.dfe_chan) && dfe_ofs_ok(st_reg.dfe_ofs))
			begin
				st_next.dfe_err = 1'b0;
				st_next.op = eqr_pkg::OP_DFE;
				st_next.op_wr = mgmt_writedata[eqr_pkg::CSR_WR_BIT];
				st_next.op_cnt = '0;
			end
			else
				st_next.dfe_err = 1'b1;
		end
		if (aeq_cmd)
		begin
			if (aeq_ok)
			begin
				st_next.aeq_err = 1'b0;
				st_next.op = eqr_pkg::OP_AEQ;
				st_next.op_wr = mgmt_writedata[eqr_pkg::CSR_WR_BIT];
				st_next.op_cnt = '0;
			end
			else
				st_next.aeq_err = 1'b1;
		end

		// One shared engine adapts one lane; it always ends after ADAPT_CYCLES
		// cycles unless a later mode write restarts or stops it, then sets done.
		// completion flag
		if (st_reg.ad_run)
		begin
			if (st_reg.ad_cnt == ACW'(ADAPT_CYCLES - 1))
			begin
				st_next.ad_run = 1'b0;
				st_next.done[st_reg.ad_ch] = 1'b1;
				st_next.result[st_reg.ad_ch] = aeq_result_in[st_reg.ad_ch];
			end
			else
				st_next.ad_cnt = st_reg.ad_cnt + 1'b1;
		end

		// Busy counts up to a fixed operation length.
		// busy while running
		case (st_reg.op)
			eqr_pkg::OP_DFE, eqr_pkg::OP_AEQ:
			begin
				if (dfe_fin || aeq_fin)
					st_next.op = eqr_pkg::OP_IDLE;
				else
					st_next.op_cnt = st_reg.op_cnt + 1'b1;
			end
			eqr_pkg::OP_IDLE: ;
			default: st_next.op = eqr_pkg::OP_IDLE;
		endcase

		if (dfe_fin && st_reg.op_wr)
		begin
			case (st_reg.dfe_ofs)
				eqr_pkg::DFE_CTRL_OFS:
				begin
					st_next.pwr[dch] = st_reg.dfe_data[eqr_pkg::CTRL_PWR_BIT];
					st_next.adapt[dch] = st_reg.dfe_data[eqr_pkg::CTRL_ADAPT_BIT];
					if (!st_reg.dfe_data[eqr_pkg::CTRL_PWR_BIT])
						st_next.trig[dch] = 1'b0;
				end
				eqr_pkg::DFE_TAP1_OFS: st_next.tap1[dch] = st_reg.dfe_data[3:0];
				eqr_pkg::DFE_TAP2_OFS, eqr_pkg::DFE_TAP3_OFS,
				eqr_pkg::DFE_TAP4_OFS: st_next.tap[dch][ti] = st_reg.dfe_data[3:0];
				eqr_pkg::DFE_TAP5_OFS:
				begin
					st_next.tap[dch][ti] = {st_reg.dfe_data[eqr_pkg::TAP_SIGN_BIT],
						(st_reg.dfe_data[2:0] > eqr_pkg::TAP5_COEF_MAX) ?
						eqr_pkg::TAP5_COEF_MAX : st_reg.dfe_data[2:0]};
				end
				eqr_pkg::DFE_TRIG_OFS:
				begin
					st_next.pwr[dch] = 1'b1;
					st_next.trig[dch] = 1'b1;
				end
				default: ;
			endcase
		end

		if (dfe_fin && !st_reg.op_wr)
		begin
			st_next.dfe_data = '0;
			case (st_reg.dfe_ofs)
				eqr_pkg::DFE_CTRL_OFS:
				begin
					st_next.dfe_data[eqr_pkg::CTRL_PWR_BIT] = st_reg.pwr[dch];
					st_next.dfe_data[eqr_pkg::CTRL_ADAPT_BIT] = st_reg.adapt[dch];
				end
				eqr_pkg::DFE_TAP1_OFS: st_next.dfe_data[3:0] = st_reg.tap1[dch];
				eqr_pkg::DFE_TAP2_OFS, eqr_pkg::DFE_TAP3_OFS,
				eqr_pkg::DFE_TAP4_OFS,
				eqr_pkg::DFE_TAP5_OFS: st_next.dfe_data[3:0] = st_reg.tap[dch][ti];
				eqr_pkg::DFE_TRIG_OFS: st_next.dfe_data[0] = st_reg.trig[dch];
				default: ;
			endcase
		end

		if (aeq_fin && st_reg.op_wr && (st_reg.aeq_ofs == eqr_pkg::AEQ_MODE_OFS))
		begin
			st_next.mode[ach] = st_reg.aeq_data[1:0];
			// A lane whose adaptation ends in this cycle keeps its done flag.
			if (!(st_reg.ad_run && (st_reg.ad_ch == ach) &&
				(st_reg.ad_cnt == ACW'(ADAPT_CYCLES - 1))))
				st_next.done[ach] = 1'b0;
			if (st_reg.aeq_data[1:0] == eqr_pkg::AEQ_MODE_ONCE)
			begin
				st_next.ad_run = 1'b1;
				st_next.ad_ch = ach;
				st_next.ad_cnt = '0;
			end
			else if (st_reg.ad_run && (st_reg.ad_ch == ach))
				st_next.ad_run = 1'b0;
		end
		if (aeq_fin && !st_reg.op_wr)
		begin
			st_next.aeq_data = '0;
			if (st_reg.aeq_ofs == eqr_pkg::AEQ_MODE_OFS)
			begin
				st_next.aeq_data[1:0] = st_reg.mode[ach];
				st_next.aeq_data[eqr_pkg::AEQ_DONE_BIT] = st_reg.done[ach];
			end
			else
				st_next.aeq_data[3:0] = st_reg.result[ach];
		end

		// Read data is registered; unmapped words and reserved bits are 0.
		// reserved reads zero
		if (mgmt_read)
		begin
			st_next.rdata = '0;
			case (mgmt_address)
				eqr_pkg::DFE_CHAN_ADDR: st_next.rdata[9:0] = st_reg.dfe_chan;
				eqr_pkg::DFE_CSR_ADDR: st_next.rdata = csr_word(dfe_busy, st_reg.dfe_err);
				eqr_pkg::DFE_OFS_ADDR: st_next.rdata[5:0] = st_reg.dfe_ofs;
				eqr_pkg::DFE_DATA_ADDR: st_next.rdata[15:0] = st_reg.dfe_data;
				eqr_pkg::AEQ_CHAN_ADDR: st_next.rdata[9:0] = st_reg.aeq_chan;
				eqr_pkg::AEQ_CSR_ADDR: st_next.rdata = csr_word(aeq_busy, st_reg.aeq_err);
				eqr_pkg::AEQ_OFS_ADDR: st_next.rdata[3:0] = st_reg.aeq_ofs;
				eqr_pkg::AEQ_DATA_ADDR: st_next.rdata[15:0] = st_reg.aeq_data;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register; reset must stay low until the lane clock settles.
	// held in reset
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// Every output is a state flip-flop.
	assign mgmt_readdata = st_reg.rdata;
	assign dfe_power = st_reg.pwr;
	assign dfe_adapt_en = st_reg.adapt;
	assign dfe_trig = st_reg.trig;
	assign dfe_tap1 = st_reg.tap1;
	assign dfe_tap = st_reg.tap;
	assign aeq_mode = st_reg.mode;
	assign aeq_done = st_reg.done;

	////////////////////////////////////////////////////////////////////////
	// Checks on the sequencer and the applied settings.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	localparam int OPW = OP_CYCLES;

	sequence s_dfe_cmd_ok;
		dfe_cmd && chan_ok(st_reg.dfe_chan) && dfe_ofs_ok(st_reg.dfe_ofs);
	endsequence

	sequence s_dfe_wr_done(logic [5:0] o);
		dfe_fin && st_reg.op_wr && (st_reg.dfe_ofs == o);
	endsequence

	a_cmd_starts_busy: assert property (s_dfe_cmd_ok |=> dfe_busy ##[0:OPW] !dfe_busy)
		else $error("accepted command did not run a bounded busy phase");
	a_busy_ends_commit: assert property ($fell(dfe_busy) |-> $past(dfe_fin))
		else $error("busy dropped without finishing the operation");
	a_error_bad_chan: assert property (dfe_cmd && !chan_ok(st_reg.dfe_chan) |=> st_reg.dfe_err && !dfe_busy)
		else $error("invalid channel did not raise error");
	a_power_applied: assert property (s_dfe_wr_done(eqr_pkg::DFE_CTRL_OFS) |=> dfe_power[$past(dch)] == $past(st_reg.dfe_data[1]))
		else $error("power bit not applied");
	a_trig_enter: assert property (s_dfe_wr_done(eqr_pkg::DFE_TRIG_OFS) |=> dfe_trig[$past(dch)] && dfe_power[$past(dch)])
		else $error("triggered mode not entered");
	a_trig_leave: assert property (dfe_fin && st_reg.op_wr && st_reg.dfe_ofs == eqr_pkg::DFE_CTRL_OFS && !st_reg.dfe_data[1] |=> !dfe_trig[$past(dch)])
		else $error("triggered mode not left on power down");
	a_tap5_limit: assert property (s_dfe_wr_done(eqr_pkg::DFE_TAP5_OFS) |=> dfe_tap[$past(dch)][3][2:0] <= eqr_pkg::TAP5_COEF_MAX)
		else $error("fifth tap coefficient out of range");
	a_tap1_applied: assert property ($fell(dfe_busy) && $past(st_reg.op_wr) && $past(st_reg.dfe_ofs) == eqr_pkg::DFE_TAP1_OFS |-> dfe_tap1[$past(dch)] == $past(st_reg.dfe_data[3:0]))
		else $error("first tap not applied when busy dropped");
	a_trig_readback: assert property (dfe_fin && !st_reg.op_wr && st_reg.dfe_ofs == eqr_pkg::DFE_TRIG_OFS |=> st_reg.dfe_data == {15'h0000, dfe_trig[$past(dch)]})
		else $error("triggered mode readback wrong");
	a_unmapped_zero: assert property (mgmt_read && !in_map(mgmt_address) |=> mgmt_readdata == '0)
		else $error("unmapped read not zero");
	a_aeq_error: assert property (aeq_cmd && !chan_ok(st_reg.aeq_chan) |=> st_reg.aeq_err && !aeq_busy)
		else $error("linear set invalid channel not flagged");
	a_adapt_done: assert property (st_reg.ad_run && st_reg.ad_cnt == ACW'(ADAPT_CYCLES - 1) |=> aeq_done[$past(st_reg.ad_ch)])
		else $error("adaptation end did not set done");

endmodule

// >>> core/eqr_pkg.sv
package eqr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Direct register addresses on the 7-bit management port.
	localparam logic [6:0] DFE_CHAN_ADDR = 7'h18;
	localparam logic [6:0] DFE_CSR_ADDR = 7'h1A;
	localparam logic [6:0] DFE_OFS_ADDR = 7'h1B;
	localparam logic [6:0] DFE_DATA_ADDR = 7'h1C;
	localparam logic [6:0] AEQ_CHAN_ADDR = 7'h28;
	localparam logic [6:0] AEQ_CSR_ADDR = 7'h2A;
	localparam logic [6:0] AEQ_OFS_ADDR = 7'h2B;
	localparam logic [6:0] AEQ_DATA_ADDR = 7'h2C;

	// Control and status bit positions, shared by both register sets.
	localparam int CSR_ERR_BIT = 9;
	localparam int CSR_BUSY_BIT = 8;
	localparam int CSR_RD_BIT = 1;
	localparam int CSR_WR_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// Indirect feedback equalizer offsets and fields.
	localparam logic [5:0] DFE_CTRL_OFS = 6'h00;
	localparam logic [5:0] DFE_TAP1_OFS = 6'h01;
	localparam logic [5:0] DFE_TAP2_OFS = 6'h02;
	localparam logic [5:0] DFE_TAP3_OFS = 6'h03;
	localparam logic [5:0] DFE_TAP4_OFS = 6'h04;
	localparam logic [5:0] DFE_TAP5_OFS = 6'h05;
	localparam logic [5:0] DFE_TRIG_OFS = 6'h0B;
	localparam int CTRL_PWR_BIT = 1;
	localparam int CTRL_ADAPT_BIT = 0;
	localparam int TAP_SIGN_BIT = 3;
	localparam logic [2:0] TAP5_COEF_MAX = 3'h3;

	// Indirect linear equalizer offsets and fields.
	localparam logic [3:0] AEQ_MODE_OFS = 4'h0;
	localparam logic [3:0] AEQ_RESULT_OFS = 4'h1;
	localparam int AEQ_DONE_BIT = 8;
	localparam logic [1:0] AEQ_MODE_MANUAL = 2'h0;
	localparam logic [1:0] AEQ_MODE_ONCE = 2'h1;

	////////////////////////////////////////////////////////////////////////
	// Default sizes and timing counts in reference clock cycles.
	localparam int NUM_CH_DEF = 4;
	localparam int OP_CYCLES_DEF = 4;
	localparam int ADAPT_CYCLES_DEF = 50000;

	// Operation sequencer states.
	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_DFE = 2'b01,
		OP_AEQ = 2'b10
	} eqr_op_e;

endpackage

// >>> dv/eqr_host.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Host master on the management port. Released address and data lines
// carry the inverse of the last value, so a late sample shows garbage.
module eqr_host (
	input wire logic ref_clk, // Reconfiguration clock.
	output logic [6:0] mgmt_address, // Word address.
	output logic mgmt_read, // Read strobe.
	output logic mgmt_write, // Write strobe.
	output logic [31:0] mgmt_writedata, // Write data.
	input wire logic [31:0] mgmt_readdata // Registered read data.
);
	// Quiet bus at time zero.
	initial
	begin
		mgmt_address = 7'h7F;
		mgmt_read = 1'b0;
		mgmt_write = 1'b0;
		mgmt_writedata = 32'hFFFF_FFFF;
	end

	// One write strobe of one cycle.
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
	begin
		@(posedge ref_clk);
		mgmt_address <= a;
		mgmt_writedata <= d;
		mgmt_write <= 1'b1;
		@(posedge ref_clk);
		mgmt_write <= 1'b0;
		mgmt_address <= ~a;
		mgmt_writedata <= ~d;
	end
	endtask

	// One read strobe; data is valid the cycle after it is taken.
	task automatic rd(input logic [6:0] a, output logic [31:0] d);
	begin
		@(posedge ref_clk);
		mgmt_address <= a;
		mgmt_read <= 1'b1;
		@(posedge ref_clk);
		mgmt_read <= 1'b0;
		mgmt_address <= ~a;
		#1;
		d = mgmt_readdata;
	end
	endtask

	// idle, stage, command, poll
	// Status is returned after busy drops, with the first busy seen.
	task automatic cmd(input logic [6:0] b, input logic [9:0] ch,
		input logic [5:0] o, input logic [15:0] d, input logic rdc,
		output logic [31:0] st, output logic b1);
		int n;
	begin
		st = 32'h0000_0100;
		for (n = 0; n < 50 && st[8] !== 1'b0; n++)
			rd(b + 7'h02, st);
		wr(b, {22'h0, ch});
		wr(b + 7'h03, {26'h0, o});
		if (!rdc)
			wr(b + 7'h04, {16'h0, d});
		wr(b + 7'h02, {30'h0, rdc, !rdc});
		rd(b + 7'h02, st);
		b1 = st[8];
		for (n = 0; n < 50 && st[8] !== 1'b0; n++)
			rd(b + 7'h02, st);
		// A busy flag that never drops counts as a mismatch.
		if (st[8] !== 1'b0)
			eqr_regs_bench.miscompares++;
	end
	endtask
endmodule

// >>> dv/eqr_regs_bench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Self-checking bench: each scenario is a task that judges its result.
module eqr_regs_bench;
	localparam int ADAPT = 20;
	localparam logic [6:0] DC = eqr_pkg::DFE_CHAN_ADDR;
	localparam logic [6:0] AC = eqr_pkg::AEQ_CHAN_ADDR;
	logic ref_clk;
	logic rst_n;
	logic [6:0] mgmt_address;
	logic mgmt_read;
	logic mgmt_write;
	logic [31:0] mgmt_writedata;
	logic [31:0] mgmt_readdata;
	logic [3:0][3:0] res;
	logic [3:0] dfe_power;
	logic [3:0] dfe_adapt_en;
	logic [3:0] dfe_trig;
	logic [3:0][3:0] dfe_tap1;
	logic [3:0][3:0][3:0] dfe_tap;
	logic [3:0][1:0] aeq_mode;
	logic [3:0] aeq_done;
	logic [31:0] st;
	logic b1;
	int miscompares;
	int tests_run;

	eqr_host host (.ref_clk(ref_clk), .mgmt_address(mgmt_address),
		.mgmt_read(mgmt_read), .mgmt_write(mgmt_write),
		.mgmt_writedata(mgmt_writedata), .mgmt_readdata(mgmt_readdata));

	// Adaptation is shortened so the done flag arrives in 20 cycles.
	eqr_regs #(.NUM_CH(4), .OP_CYCLES(4), .ADAPT_CYCLES(ADAPT)) uut (
		.ref_clk(ref_clk), .rst_n(rst_n), .mgmt_address(mgmt_address),
		.mgmt_read(mgmt_read), .mgmt_write(mgmt_write),
		.mgmt_writedata(mgmt_writedata), .mgmt_readdata(mgmt_readdata),
		.aeq_result_in(res), .dfe_power(dfe_power),
		.dfe_adapt_en(dfe_adapt_en), .dfe_trig(dfe_trig),
		.dfe_tap1(dfe_tap1), .dfe_tap(dfe_tap), .aeq_mode(aeq_mode),
		.aeq_done(aeq_done));

	// Free-running 250 MHz clock.
	always #2 ref_clk = ~ref_clk;

	// Compare one value and count it.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
	begin
		tests_run++;
		if (seen !== exp)
		begin
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			miscompares++;
		end
	end
	endtask

	// Outputs and registers start cleared; unmapped reads give zero.
	task automatic t_reset();
	begin
		chk(32'({dfe_power, dfe_adapt_en, dfe_trig, aeq_done}), 0);
		chk(32'({dfe_tap1, aeq_mode}), 0);
		chk(dfe_tap[3:2], 0);
		chk(dfe_tap[1:0], 0);
		host.rd(DC + 7'h02, st);
		chk(st, 0);
		host.rd(7'h00, st);
		chk(st, 0);
	end
	endtask

	// Register widths: upper bits of an all-ones write are dropped.
	task automatic t_widths();
		logic [6:0] ad [7] = '{7'h18, 7'h1B, 7'h1C, 7'h28, 7'h2B, 7'h2C,
			7'h05};
		logic [31:0] ex [7] = '{32'h0000_03FF, 32'h0000_003F, 32'h0000_FFFF,
			32'h0000_03FF, 32'h0000_000F, 32'h0000_FFFF, 32'h0000_0000};
	begin
		for (int i = 0; i < 7; i++)
		begin
			host.wr(ad[i], 32'hFFFF_FFFF);
			host.rd(ad[i], st);
			chk(st, ex[i]);
		end
	end
	endtask

	// Continuous and manual modes, taps and a read-back on lane 2.
	task automatic t_dfe();
		logic [3:0] tv [3] = '{4'h7, 4'hA, 4'h5};
	begin
		host.cmd(DC, 2, 0, 3, 0, st, b1);
		chk(b1, 1);
		chk(st[9:8], 0);
		chk({dfe_power[2], dfe_adapt_en[2]}, 2'b11);
		host.cmd(DC, 2, 0, 2, 0, st, b1);
		chk({dfe_power[2], dfe_adapt_en[2]}, 2'b10);
		chk(dfe_power[1], 0);
		host.cmd(DC, 2, 0, 0, 1, st, b1);
		host.rd(DC + 7'h04, st);
		chk(st, 32'h0000_0002);
		host.cmd(DC, 2, 1, 15, 0, st, b1);
		chk(dfe_tap1[2], 4'hF);
		host.cmd(DC, 2, 1, 5, 0, st, b1);
		host.cmd(DC, 2, 1, 0, 1, st, b1);
		host.rd(DC + 7'h04, st);
		chk(st, 5);
		for (int i = 0; i < 3; i++)
		begin
			host.cmd(DC, 2, 6'(i + 2), 16'(tv[i]), 0, st, b1);
			chk(dfe_tap[2][i], tv[i]);
		end
		host.cmd(DC, 2, 3, 0, 1, st, b1);
		host.rd(DC + 7'h04, st);
		chk(st, 32'h0000_000A);
		host.cmd(DC, 2, 5, 16'h000F, 0, st, b1);
		chk(dfe_tap[2][3], 4'hB);
		host.cmd(DC, 2, 5, 16'h0002, 0, st, b1);
		chk(dfe_tap[2][3], 4'h2);
	end
	endtask

	// Triggered mode entered by a zero write, left by power off.
	task automatic t_trig();
	begin
		host.cmd(DC, 3, 6'h0B, 0, 0, st, b1);
		chk({dfe_power[3], dfe_trig[3]}, 2'b11);
		host.cmd(DC, 3, 6'h0B, 0, 1, st, b1);
		host.rd(DC + 7'h04, st);
		chk(st[0], 1);
		host.cmd(DC, 3, 0, 0, 0, st, b1);
		chk({dfe_power[3], dfe_trig[3]}, 2'b00);
	end
	endtask

	// Bad channel or offset sets the error flag with no busy.
	task automatic t_err();
	begin
		host.cmd(DC, 4, 0, 3, 0, st, b1);
		chk({st[9:8], b1}, 3'b100);
		chk(dfe_power, 4'h4);
		host.cmd(DC, 0, 6, 1, 0, st, b1);
		chk(st[9], 1);
		host.cmd(DC, 0, 1, 1, 0, st, b1);
		chk(st[9], 0);
	end
	endtask

	// Linear set: one-time adaptation, result, reserved mode, bad lane.
	task automatic t_aeq();
		int n;
	begin
		@(posedge ref_clk);
		res <= 16'h0090;
		host.cmd(AC, 1, 0, 1, 0, st, b1);
		chk({aeq_mode[1], aeq_done[1]}, 3'b010);
		for (n = 0; n < ADAPT + 40 && aeq_done[1] !== 1'b1; n++)
			@(posedge ref_clk);
		chk(aeq_done[1], 1);
		host.cmd(AC, 1, 0, 0, 1, st, b1);
		host.rd(AC + 7'h04, st);
		chk(st, 32'h0000_0101);
		host.cmd(AC, 1, 1, 0, 1, st, b1);
		host.rd(AC + 7'h04, st);
		chk(st, 32'h0000_0009);
		host.cmd(AC, 1, 0, 2, 0, st, b1);
		chk({st[9], aeq_mode[1]}, 3'b101);
		host.cmd(AC, 5, 0, 1, 0, st, b1);
		chk(st[9:8], 2'b10);
		host.cmd(AC, 1, 0, 0, 0, st, b1);
		chk({aeq_mode[1], aeq_done[1]}, 3'b000);
	end
	endtask

	// Print counts and the verdict, then stop.
	task automatic results();
	begin
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask

	// reset held first
	// Main sequence; reset stands for eight cycles before any access.
	initial
	begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		res = '0;
		miscompares = 0;
		tests_run = 0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_widths();
		t_dfe();
		t_trig();
		t_err();
		t_aeq();
		results();
	end

	// Watchdog: the run needs a few hundred cycles, so 20000 is ample.
	initial
	begin
		#80000;
		miscompares++;
		results();
	end
endmodule
